// ---- hw/cise_core.sv ----
// subset executor: register file, accumulator, pc, stack, flags
// assumes one instruction offered per free cycle on same clock;
// wake request comes from logic on sys_clk so no synchroniser
`timescale 1ns/1ns
// Functional notes
// - bit test skip set: bit one discards next instruction, two cycles.
// - watchdog kick clears counter and prescaler, sets both flags.
// - subroutine jump pushes next address, loads 11-bit literal into pc.
// - pc bits 12 and 11 come from latch bits 4 and 3.
// - subroutine jump takes two cycles; jump and bit test touch no flags.
// - complement inverts register; destination bit picks accumulator or register.
// - clear register writes zero and sets the zero flag.
// - clear accumulator writes zero and sets the zero flag only.
// - decrement subtracts one; destination bit picks accumulator or register.
// - wake by interrupt with global enable loads the interrupt vector.
module cise_core #(
    parameter int WDT_W = 8,
    parameter int PRESC_W = 8,
    parameter int REG_COUNT = 128
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // instruction issue
    input wire logic instValid,
    input wire cise_pkg::cise_op_t instOp,
    input wire logic [6:0] instAddr,
    input wire logic [2:0] instBit,
    input wire logic instDest,
    input wire logic [10:0] instLiteral,
    // software register writes from outside
    input wire logic latchWrite,
    input wire logic [7:0] latchData,
    input wire logic globalIrqAllowIn,
    // sleep and wake
    input wire logic sleepEnter,
    input wire logic wakeIrq,
    // execution state
    output logic instReady,
    output logic [12:0] progCounter,
    output logic [7:0] accumulator,
    // status flags
    output logic resultNullFlag,
    output logic timeoutFlag,
    output logic powerdownFlag,
    // watchdog
    output logic [WDT_W-1:0] watchdogCount,
    output logic [PRESC_W-1:0] watchdogPrescale,
    // return stack
    output logic [2:0] stackDepth,
    output logic [12:0] stackTop,
    // sleep and skip
    output logic asleep,
    output logic skipPending,
    // software registers as seen by the core
    output logic [7:0] upperPcLatch,
    output logic globalIrqAllow
);
    typedef enum logic [1:0] {
        ST_RUN,
        ST_SECOND,
        ST_SLEEP
    } cise_state_t;

    typedef struct packed {
        cise_state_t state;
        logic [12:0] pc;
        logic [7:0] acc;
        logic zero;
        logic timeout;
        logic powerdown;
        logic [WDT_W-1:0] wdt;
        logic [PRESC_W-1:0] presc;
        logic [2:0] sp;
        logic [cise_pkg::STACK_DEPTH-1:0][12:0] stack;
        logic [REG_COUNT-1:0][7:0] regs;
        logic [7:0] latch;
        logic irqAllow;
        logic skip;
        // decoded copies kept in flops so no output comes from gates
        logic ready;
        logic sleeping;
        logic [12:0] top;
    } cise_core_t;

    cise_core_t cur;
    cise_core_t next_cur;
    logic [7:0] operand;
    logic [7:0] aluResult;
    logic aluZero;
    logic [12:0] pcPlusOne;

    assign operand = cur.regs[instAddr];
    assign pcPlusOne = cur.pc + 13'h0001;

    cise_alu cise_alu_i (
        .op(instOp),
        .operand(operand),
        .result(aluResult),
        .resultZero(aluZero)
    );

    // issue decode shared by the per-entry write logic below
    logic taken;
    logic resultToReg;
    logic regWrite;
    logic [7:0] regWriteData;
    logic pushEnable;
    logic [7:0] bitHit;
    logic testedBit;
    logic [WDT_W+PRESC_W-1:0] wdtChain;
    logic [REG_COUNT-1:0][7:0] regNext;
    logic [cise_pkg::STACK_DEPTH-1:0][12:0] stackNext;

    // sleep request wins over a valid instruction in the same cycle
    assign taken = cur.ready && instValid && !sleepEnter;
    assign resultToReg = instDest
        && (instOp == cise_pkg::OP_COMPLEMENT_REG
        || instOp == cise_pkg::OP_DECREMENT_REG);
    assign regWrite = taken
        && (resultToReg || instOp == cise_pkg::OP_CLEAR_REG);
    assign regWriteData = (instOp == cise_pkg::OP_CLEAR_REG)
        ? cise_pkg::ZERO_BYTE : aluResult;
    assign pushEnable = taken
        && instOp == cise_pkg::OP_SUBROUTINE_JUMP;

    // watchdog and prescaler count as one chain
    assign wdtChain = {cur.wdt, cur.presc}
        + {{(WDT_W+PRESC_W-1){1'b0}}, 1'b1};

    // one-hot bit select keeps the skip test a plain and-or tree
    for (genvar b = 0; b < 8; b++) begin : g_bit
        assign bitHit[b] = operand[b] && (instBit == 3'(b));
    end
    assign testedBit = |bitHit;

    // register file: an entry changes only when addressed
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
        assign regNext[i] = (regWrite && instAddr == 7'(i))
            ? regWriteData : cur.regs[i];
    end

    // return stack: the slot under the pointer takes the return address;
    // a full stack wraps and the oldest return is lost
    for (genvar s = 0; s < cise_pkg::STACK_DEPTH; s++) begin : g_stack
        assign stackNext[s] = (pushEnable && cur.sp == 3'(s))
            ? pcPlusOne : cur.stack[s];
    end

    always_comb begin
        next_cur = cur;
        if (latchWrite) begin
            next_cur.latch = latchData;
        end
        next_cur.irqAllow = globalIrqAllowIn;
        // free-running watchdog; kick below takes priority
        {next_cur.wdt, next_cur.presc} = wdtChain;
        next_cur.regs = regNext;
        next_cur.stack = stackNext;
        case (cur.state)
            ST_RUN: begin
                if (sleepEnter) begin
                    next_cur.state = ST_SLEEP;
                    next_cur.powerdown = 1'b0;
                end else if (instValid) begin
                    next_cur.pc = pcPlusOne;
                    case (instOp)
                        cise_pkg::OP_BIT_TEST_SKIP_SET: begin
                            if (testedBit) begin
                                next_cur.state = ST_SECOND;
                                next_cur.skip = 1'b1;
                            end
                        end
                        cise_pkg::OP_WATCHDOG_KICK: begin
                            next_cur.wdt = '0;
                            next_cur.presc = '0;
                            next_cur.timeout = 1'b1;
                            next_cur.powerdown = 1'b1;
                        end
                        cise_pkg::OP_SUBROUTINE_JUMP: begin
                            next_cur.sp = cur.sp + 3'h1;
                            next_cur.pc = {cur.latch[
                                cise_pkg::LATCH_PAGE_HI:
                                cise_pkg::LATCH_PAGE_LO],
                                instLiteral};
                            next_cur.state = ST_SECOND;
                        end
                        cise_pkg::OP_COMPLEMENT_REG,
                        cise_pkg::OP_DECREMENT_REG: begin
                            // register copy is written by the entry loop
                            if (!instDest) begin
                                next_cur.acc = aluResult;
                            end
                            next_cur.zero = aluZero;
                        end
                        cise_pkg::OP_CLEAR_REG: begin
                            next_cur.zero = 1'b1;
                        end
                        cise_pkg::OP_CLEAR_ACCUMULATOR: begin
                            next_cur.acc = cise_pkg::ZERO_BYTE;
                            next_cur.zero = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_SECOND: begin
                // discarded slot: executes as a no-operation
                next_cur.state = ST_RUN;
                if (cur.skip) begin
                    next_cur.pc = pcPlusOne;
                end
                next_cur.skip = 1'b0;
            end
            ST_SLEEP: begin
                if (wakeIrq) begin
                    next_cur.state = ST_RUN;
                    if (cur.irqAllow) begin
                        next_cur.pc = cise_pkg::IRQ_VECTOR;
                    end
                end
            end
            default: next_cur.state = ST_RUN;
        endcase
        // decoded outputs follow the next state into their own flops
        next_cur.ready = (next_cur.state == ST_RUN);
        next_cur.sleeping = (next_cur.state == ST_SLEEP);
        next_cur.top = next_cur.stack[next_cur.sp - 3'h1];
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
            cur.state <= ST_RUN;
            cur.pc <= cise_pkg::PC_RESET;
            cur.timeout <= 1'b1;
            cur.powerdown <= 1'b1;
            cur.ready <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs are register slices of the state
    assign instReady = cur.ready;
    assign progCounter = cur.pc;
    assign accumulator = cur.acc;
    assign resultNullFlag = cur.zero;
    assign timeoutFlag = cur.timeout;
    assign powerdownFlag = cur.powerdown;
    assign watchdogCount = cur.wdt;
    assign watchdogPrescale = cur.presc;
    assign stackDepth = cur.sp;
    assign stackTop = cur.top;
    assign asleep = cur.sleeping;
    assign skipPending = cur.skip;
    assign upperPcLatch = cur.latch;
    assign globalIrqAllow = cur.irqAllow;
endmodule

// ---- hw/cise_pkg.sv ----
// constants shared by the instruction subset executor
// assumes a 13-bit program counter and 8-bit data registers
package cise_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int LIT_W = 11;
    localparam int BSEL_W = 3;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
    localparam int LATCH_PAGE_LO = 3;
    localparam int LATCH_PAGE_HI = 4;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_BIT_TEST_SKIP_SET,
        OP_WATCHDOG_KICK,
        OP_SUBROUTINE_JUMP,
        OP_COMPLEMENT_REG,
        OP_CLEAR_REG,
        OP_CLEAR_ACCUMULATOR,
        OP_DECREMENT_REG
    } cise_op_t;
endpackage

// ---- hw/cise_alu.sv ----
// combinational result unit for complement and decrement
// assumes operands already fetched from the register file
`timescale 1ns/1ns
module cise_alu (
    // operation and operand
    input wire cise_pkg::cise_op_t op,
    input wire logic [7:0] operand,
    // result
    output logic [7:0] result,
    output logic resultZero
);
    always_comb begin
        case (op)
            cise_pkg::OP_COMPLEMENT_REG: result = ~operand;
            cise_pkg::OP_DECREMENT_REG:
                result = operand - cise_pkg::ONE_BYTE;
            default: result = cise_pkg::ZERO_BYTE;
        endcase
        resultZero = (result == cise_pkg::ZERO_BYTE);
    end
endmodule

// ---- sim/cise_chk.sv ----
// port-level assertions for cise_core
// bound to every cise_core; single clock domain
`timescale 1ns/1ns
module cise_chk #(parameter int WDT_W = 8, parameter int PRESC_W = 8) (
    // clock, reset, issue
    input wire logic sys_clk, rstn, instValid, instDest, sleepEnter,
    input wire cise_pkg::cise_op_t instOp,
    input wire logic [10:0] instLiteral,
    // status
    input wire logic instReady, resultNullFlag, timeoutFlag, powerdownFlag,
    input wire logic skipPending,
    input wire logic [12:0] progCounter, stackTop,
    input wire logic [7:0] accumulator, upperPcLatch,
    input wire logic [WDT_W-1:0] watchdogCount,
    input wire logic [PRESC_W-1:0] watchdogPrescale
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire tk = instValid && instReady && !sleepEnter;
    wire j = tk && instOp == cise_pkg::OP_SUBROUTINE_JUMP;
    wire b = tk && instOp == cise_pkg::OP_BIT_TEST_SKIP_SET;
    wire k = tk && instOp == cise_pkg::OP_WATCHDOG_KICK;
    wire ca = tk && instOp == cise_pkg::OP_CLEAR_ACCUMULATOR;
    wire cr = tk && instOp == cise_pkg::OP_CLEAR_REG;
    wire cd = tk && !instDest && (instOp == cise_pkg::OP_COMPLEMENT_REG
        || instOp == cise_pkg::OP_DECREMENT_REG);
    sequence s_two;
        !instReady ##1 instReady;
    endsequence
    property p_skip;
        b ##1 skipPending |-> s_two
            ##0 progCounter == $past(progCounter, 2) + 13'h2;
    endproperty
    property p_kick;
        k |=> watchdogCount == '0 && watchdogPrescale == '0
            && timeoutFlag && powerdownFlag;
    endproperty
    property p_push;
        j |=> stackTop == $past(progCounter) + 13'h1
            && progCounter[10:0] == $past(instLiteral);
    endproperty
    property p_page;
        j |=> progCounter[12:11] == $past(upperPcLatch[4:3]);
    endproperty
    property p_jtime;
        j |=> s_two;
    endproperty
    property p_noflag;
        j || b |=> $stable(resultNullFlag);
    endproperty
    property p_clr;
        cr || ca |=> resultNullFlag && (!$past(ca) || accumulator == 8'h00);
    endproperty
    property p_zero;
        cd |=> resultNullFlag == (accumulator == 8'h00);
    endproperty
    a_skip: assert property (p_skip) else $error("skip timing wrong");
    a_kick: assert property (p_kick) else $error("kick wrong");
    a_push: assert property (p_push) else $error("call push wrong");
    a_page: assert property (p_page) else $error("call page wrong");
    a_jtime: assert property (p_jtime) else $error("call length");
    a_noflag: assert property (p_noflag) else $error("flag moved");
    a_clr: assert property (p_clr) else $error("clear wrong");
    a_zero: assert property (p_zero) else $error("zero flag");
endmodule
bind cise_core cise_chk #(.WDT_W(WDT_W), .PRESC_W(PRESC_W)) cise_chk_i (
    .sys_clk(sys_clk), .rstn(rstn), .instValid(instValid),
    .instDest(instDest), .sleepEnter(sleepEnter), .instOp(instOp),
    .instLiteral(instLiteral), .instReady(instReady),
    .resultNullFlag(resultNullFlag), .timeoutFlag(timeoutFlag),
    .powerdownFlag(powerdownFlag), .skipPending(skipPending),
    .progCounter(progCounter), .stackTop(stackTop),
    .accumulator(accumulator), .upperPcLatch(upperPcLatch),
    .watchdogCount(watchdogCount), .watchdogPrescale(watchdogPrescale)
);

// ---- sim/test_cise_core.sv ----
// self-checking bench for cise_core with a behavioural model
// bench drives every input; registers start at zero after reset
`timescale 1ns/1ns
module test_cise_core;
    logic sys_clk = 1'b0, rstn = 1'b0, instValid = 1'b0, instDest = 1'b0;
    logic latchWrite = 1'b0, globalIrqAllowIn = 1'b0, sleepEnter = 1'b0;
    logic wakeIrq = 1'b0, instReady, resultNullFlag, timeoutFlag;
    logic powerdownFlag, asleep, skipPending, globalIrqAllow;
    cise_pkg::cise_op_t instOp = cise_pkg::OP_NOP, rop;
    logic [6:0] instAddr = 7'h00;
    logic [2:0] instBit = 3'h0, stackDepth;
    logic [10:0] instLiteral = 11'h000;
    logic [7:0] latchData = 8'h00, accumulator, upperPcLatch, acc, lat, r;
    logic [7:0] watchdogCount, watchdogPrescale, mem [128];
    logic [12:0] progCounter, stackTop, pc;
    logic z;
    logic [2:0] sd;
    logic [31:0] seed = 32'h56AA;
    int err_count = 0, checks = 0;
    always #4 sys_clk = ~sys_clk;
    cise_core cise_core_i (
        .sys_clk(sys_clk), .rstn(rstn), .instValid(instValid),
        .instOp(instOp), .instAddr(instAddr), .instBit(instBit),
        .instDest(instDest), .instLiteral(instLiteral),
        .latchWrite(latchWrite), .latchData(latchData),
        .globalIrqAllowIn(globalIrqAllowIn), .sleepEnter(sleepEnter),
        .wakeIrq(wakeIrq), .instReady(instReady),
        .progCounter(progCounter), .accumulator(accumulator),
        .resultNullFlag(resultNullFlag), .timeoutFlag(timeoutFlag),
        .powerdownFlag(powerdownFlag), .watchdogCount(watchdogCount),
        .watchdogPrescale(watchdogPrescale), .stackDepth(stackDepth),
        .stackTop(stackTop), .asleep(asleep), .skipPending(skipPending),
        .upperPcLatch(upperPcLatch), .globalIrqAllow(globalIrqAllow)
    );
    function logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic [7:0] res(cise_pkg::cise_op_t o, logic [7:0] v);
        if (o == cise_pkg::OP_COMPLEMENT_REG) return ~v;
        if (o == cise_pkg::OP_DECREMENT_REG) return v - 8'h01;
        return 8'h00;
    endfunction
    task cmpv(string n, logic [12:0] e, logic [12:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task cmpf(string n, logic e, logic g);
        cmpv(n, {12'h000, e}, {12'h000, g});
    endtask
    task summarize;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one instruction, then an idle cycle before comparing final state
    task issue(cise_pkg::cise_op_t o, logic [6:0] a, logic [2:0] b,
            logic d, logic [10:0] k);
        logic two;
        two = o == cise_pkg::OP_SUBROUTINE_JUMP
            || (o == cise_pkg::OP_BIT_TEST_SKIP_SET && mem[a][b]);
        @(posedge sys_clk);
        instValid <= 1'b1;
        instOp <= o;
        instAddr <= a;
        instBit <= b;
        instDest <= d;
        instLiteral <= k;
        @(posedge sys_clk);
        instValid <= 1'b0;
        r = res(o, o == cise_pkg::OP_CLEAR_ACCUMULATOR ? acc : mem[a]);
        if (o inside {[cise_pkg::OP_COMPLEMENT_REG:
                cise_pkg::OP_DECREMENT_REG]}) begin
            z = r == 8'h00;
            if (o == cise_pkg::OP_CLEAR_ACCUMULATOR
                || (o != cise_pkg::OP_CLEAR_REG && !d)) acc = r;
            else mem[a] = r;
        end
        #1 cmpf("instReady", !two, instReady);
        if (o == cise_pkg::OP_SUBROUTINE_JUMP) begin
            cmpv("stackTop", pc + 13'h1, stackTop);
            sd = sd + 3'h1;
            cmpv("stackDepth", {10'h0, sd}, {10'h0, stackDepth});
            pc = {lat[4:3], k};
        end else pc = pc + (two ? 13'h2 : 13'h1);
        if (o == cise_pkg::OP_WATCHDOG_KICK) begin
            cmpv("wdt", 13'h0, {5'h0, watchdogCount | watchdogPrescale});
            cmpf("timeout", 1'b1, timeoutFlag);
            cmpf("powerdown", 1'b1, powerdownFlag);
        end
        @(posedge sys_clk);
        #1 cmpv("pc", pc, progCounter);
        cmpv("acc", {5'h0, acc}, {5'h0, accumulator});
        cmpf("zero", z, resultNullFlag);
    endtask
    initial begin
        #100000 err_count++;
        summarize();
    end
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {acc, lat, pc, z, sd} = '0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        issue(cise_pkg::OP_DECREMENT_REG, 7'h7F, 3'h0, 1'b1, 11'h0);
        issue(cise_pkg::OP_COMPLEMENT_REG, 7'h7F, 3'h0, 1'b0, 11'h0);
        issue(cise_pkg::OP_BIT_TEST_SKIP_SET, 7'h7F, 3'h7, 1'b0, 11'h0);
        for (int g = 0; g < 2; g++) begin
            @(posedge sys_clk);
            globalIrqAllowIn <= g[0];
            sleepEnter <= 1'b1;
            @(posedge sys_clk);
            sleepEnter <= 1'b0;
            @(posedge sys_clk);
            wakeIrq <= 1'b1;
            cmpf("asleep", 1'b1, asleep);
            cmpf("irqAllow", g[0], globalIrqAllow);
            @(posedge sys_clk);
            wakeIrq <= 1'b0;
            pc = g[0] ? cise_pkg::IRQ_VECTOR : pc;
            #1 cmpv("wake pc", pc, progCounter);
            cmpf("awake", 1'b0, asleep);
        end
        issue(cise_pkg::OP_WATCHDOG_KICK, 7'h0, 3'h0, 1'b0, 11'h0);
        for (int i = 0; i < 300; i++) begin
            seed = lfsr(seed);
            if (seed[31]) begin
                @(posedge sys_clk);
                latchWrite <= 1'b1;
                latchData <= seed[29:22];
                lat = seed[29:22];
                @(posedge sys_clk);
                latchWrite <= 1'b0;
                #1 cmpv("latch", {5'h0, lat}, {5'h0, upperPcLatch});
            end
            rop = cise_pkg::cise_op_t'(seed[2:0]);
            issue(rop, {4'h0, seed[5:3]}, seed[8:6], seed[9], seed[20:10]);
        end
        summarize();
    end
endmodule
